// >>> rtl/sar_adc_pkg.sv
// Shared constants for the successive-approximation converter control core
package sar_adc_pkg;
  // Bus and register geometry, input count, buffer depth and timing
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned REG_W      = 16;
  localparam int unsigned RES_W      = 12;
  localparam int unsigned N_INPUTS   = 10;
  localparam int unsigned BUF_DEPTH  = 16;
  localparam int unsigned CONV_TADS  = 14;
  localparam int unsigned ABORT_TADS = 2;
  localparam int unsigned MAX_KSPS   = 200;
  localparam int unsigned CLK_HZ     = 50_000_000;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL_ONE   = 8'h00;
  localparam logic [7:0] OFF_CTRL_TWO   = 8'h04;
  localparam logic [7:0] OFF_CTRL_THREE = 8'h08;
  localparam logic [7:0] OFF_CHAN_SEL   = 8'h0c;
  localparam logic [7:0] OFF_PIN_CFG    = 8'h10;
  localparam logic [7:0] OFF_SCAN_SEL   = 8'h14;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h18;
  localparam logic [7:0] OFF_IRQ_MASK   = 8'h1c;
  localparam logic [7:0] OFF_RESULT     = 8'h40;
  // Field positions
  localparam int unsigned C1_ENABLE   = 15;
  localparam int unsigned C1_TRIG_LSB = 5;
  localparam int unsigned C1_AUTO     = 2;
  localparam int unsigned C1_SAMPLE   = 1;
  localparam int unsigned C1_DONE     = 0;
  localparam int unsigned C2_REF_EXT  = 13;
  localparam int unsigned C2_SCAN     = 10;
  localparam int unsigned C2_SMPI_LSB = 2;
  localparam int unsigned C2_SPLIT    = 1;
  localparam int unsigned C2_ALT      = 0;
  localparam int unsigned C3_AUTO_SAMPLE_CLOCKS_LSB = 8;
  localparam int unsigned C3_RC       = 7;
  localparam int unsigned CH_B_LSB    = 8;
  // Reset values and codes
  localparam logic [15:0] REG_RST   = 16'h0000;
  localparam logic [2:0]  TRIG_SOFT = 3'h0;
  localparam logic [2:0]  TRIG_AUTO = 3'h7;
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_SLV  = 2'h2;
  typedef enum {ST_IDLE, ST_SAMPLE, ST_CONVERT, ST_ABORT} seq_state_e;
endpackage

// >>> rtl/sar_adc_tad_timer.sv
// Conversion clock period tick generator
`timescale 1ns/100ps
`default_nettype none
module sar_adc_tad_timer
  import sar_adc_pkg::*;
(
  // Clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset,
  // Control
  input  wire logic       i_run,
  input  wire logic [5:0] i_divider,
  input  wire logic       i_rc_sel,
  input  wire logic       i_rc_tick,
  // Tick out
  output logic            o_tick
);
  logic [5:0] cnt_ff;

  // One period is the system clock period times divider plus one, or one rc tick when i_rc_sel is set
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_ff <= 6'h00;
      o_tick <= 1'b0;
    end else if (!i_run) begin
      cnt_ff <= 6'h00;
      o_tick <= 1'b0;
    end else if (i_rc_sel) begin
      cnt_ff <= 6'h00;
      o_tick <= i_rc_tick;
    end else if (cnt_ff >= i_divider) begin
      cnt_ff <= 6'h00;
      o_tick <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 6'h01;
      o_tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/sar_adc_approx.sv
// Successive approximation register, one bit resolved per tick
`timescale 1ns/100ps
`default_nettype none
module sar_adc_approx
  import sar_adc_pkg::*;
(
  // Clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_reset,
  // Control
  input  wire logic             i_start,
  input  wire logic             i_tick,
  input  wire logic             i_comp,
  // Trial code and result
  output logic [RES_W-1:0]      o_trial,
  output logic                  o_busy
);
  logic [RES_W-1:0] bit_ff;

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_trial <= '0;
      bit_ff  <= '0;
      o_busy  <= 1'b0;
    end else if (i_start) begin
      o_trial <= {1'b1, {(RES_W-1){1'b0}}};
      bit_ff  <= {1'b1, {(RES_W-1){1'b0}}};
      o_busy  <= 1'b1;
    end else if (o_busy && i_tick) begin
      // Keep or drop the bit under test, then try the next one
      o_trial <= (i_comp ? o_trial : (o_trial & ~bit_ff)) | (bit_ff >> 1);
      bit_ff  <= bit_ff >> 1;
      o_busy  <= (bit_ff != {{(RES_W-1){1'b0}}, 1'b1});
    end
  end
endmodule
`default_nettype wire

// >>> rtl/sar_adc_core.sv
// Converter control core with register slave, sequencer and result buffer
`timescale 1ns/100ps
`default_nettype none
module sar_adc_core
  import sar_adc_pkg::*;
(
  // Clock and reset
  input  wire logic                i_sys_clk,
  input  wire logic                i_reset,
  // AXI4-Lite write
  input  wire logic                i_awvalid,
  input  wire logic [ADDR_W-1:0]   i_awaddr,
  output logic                     o_awready,
  input  wire logic                i_wvalid,
  input  wire logic [DATA_W-1:0]   i_wdata,
  input  wire logic [3:0]          i_wstrb,
  output logic                     o_wready,
  output logic                     o_bvalid,
  output logic [1:0]               o_bresp,
  input  wire logic                i_bready,
  // AXI4-Lite read
  input  wire logic                i_arvalid,
  input  wire logic [ADDR_W-1:0]   i_araddr,
  output logic                     o_arready,
  output logic                     o_rvalid,
  output logic [DATA_W-1:0]        o_rdata,
  output logic [1:0]               o_rresp,
  input  wire logic                i_rready,
  // Analog front end
  input  wire logic                i_comp,
  input  wire logic                i_rc_tick,
  input  wire logic                i_ext_trig,
  input  wire logic                i_sleep,
  output logic [3:0]               o_mux_sel,
  output logic                     o_hold,
  output logic                     o_ref_ext,
  output logic [RES_W-1:0]         o_dac_code,
  output logic [N_INPUTS-1:0]      o_pin_analog,
  // Interrupt
  output logic                     o_irq
);
  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [15:0]          ctrl_one_ff, ctrl_two_ff, ctrl_three_ff;
  logic [15:0]          chan_sel_ff, pin_cfg_ff, scan_sel_ff;
  logic [15:0]          irq_mask_ff;
  logic                 irq_stat_ff;
  logic [RES_W-1:0]     result_mem [BUF_DEPTH];
  logic                 aw_have_ff, w_have_ff;
  logic [ADDR_W-1:0]    aw_addr_ff;
  logic [DATA_W-1:0]    w_data_ff;
  logic [3:0]           w_strb_ff;
  logic                 wr_go;
  logic [15:0]          wr_val, wr_one, wr_two;
  seq_state_e           state_ff;
  logic [3:0]           tad_cnt_ff;
  logic [4:0]           auto_sample_clocks_cnt_ff;
  logic [3:0]           smp_cnt_ff, scan_pos_ff, cur_ch_ff;
  logic                 half_ff, alt_b_ff;
  logic                 tick, sar_busy, start_conv, conv_end;
  logic                 hw_clr_sample, hw_set_sample, hw_set_done;
  logic                 last_smp, trig_hit, ext_rise, rc_rise;
  logic [3:0]           sync1_ff, sync2_ff, sync3_ff, filt_ff;
  logic                 ext_prev_ff, rc_prev_ff;
  logic                 enable;
  logic [2:0]           trig_sel;
  logic [3:0]           smpi, nxt_ch;
  logic [4:0]           auto_sample_clocks;

  assign enable   = ctrl_one_ff[C1_ENABLE];
  assign trig_sel = ctrl_one_ff[C1_TRIG_LSB +: 3];
  assign smpi     = ctrl_two_ff[C2_SMPI_LSB +: 4];
  assign auto_sample_clocks     = ctrl_three_ff[C3_AUTO_SAMPLE_CLOCKS_LSB +: 5];

  ////////////////////////////////////////////////////////////////////////////
  // Functions
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= OFF_IRQ_MASK ||
             (a >= OFF_RESULT && a < OFF_RESULT + 8'(BUF_DEPTH * 4)));
  endfunction

  // Lowest selected input at or above a start point, wrapping round
  function automatic logic [3:0] next_scan(input logic [15:0] sel,
                                           input logic [3:0]  from);
    logic found;
    found     = 1'b0;
    next_scan = 4'h0;
    for (int i = N_INPUTS - 1; i >= 0; i--) begin
      if (sel[i]) begin
        next_scan = 4'(i);
      end
    end
    for (int i = N_INPUTS - 1; i >= 0; i--) begin
      if (sel[i] && 4'(i) >= from) begin
        next_scan = 4'(i);
        found     = 1'b1;
      end
    end
    if (!found && from == 4'h0) begin
      next_scan = 4'h0;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: comparator, rc tick, trigger, sleep
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      sync1_ff <= 4'h0;
      sync2_ff <= 4'h0;
      sync3_ff <= 4'h0;
    end else begin
      sync1_ff <= {i_sleep, i_ext_trig, i_rc_tick, i_comp};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  generate
    for (genvar g = 0; g < 4; g++) begin : g_filt
      always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
          filt_ff[g] <= 1'b0;
        end else if (sync2_ff[g] == sync3_ff[g]) begin
          filt_ff[g] <= sync3_ff[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      rc_prev_ff  <= 1'b0;
      ext_prev_ff <= 1'b0;
    end else begin
      rc_prev_ff  <= filt_ff[1];
      ext_prev_ff <= filt_ff[2];
    end
  end

  assign rc_rise  = filt_ff[1] && !rc_prev_ff;
  assign ext_rise = filt_ff[2] && !ext_prev_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion clock and approximation
  sar_adc_tad_timer u_tad (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_run     ((state_ff != ST_IDLE) &&
                (!filt_ff[3] || ctrl_three_ff[C3_RC])),
    .i_divider (ctrl_three_ff[5:0]),
    .i_rc_sel  (ctrl_three_ff[C3_RC]),
    .i_rc_tick (rc_rise),
    .o_tick    (tick)
  );

  sar_adc_approx u_sar (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_start   (start_conv),
    .i_tick    (tick && state_ff == ST_CONVERT),
    .i_comp    (filt_ff[0]),
    .o_trial   (o_dac_code),
    .o_busy    (sar_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    trig_hit = 1'b0;
    case (trig_sel)
      TRIG_SOFT: trig_hit = !ctrl_one_ff[C1_SAMPLE];
      TRIG_AUTO: trig_hit = tick && (6'(auto_sample_clocks_cnt_ff) + 6'h01 >= 6'(auto_sample_clocks));
      default:   trig_hit = ext_rise;
    endcase
  end

  assign start_conv    = state_ff == ST_SAMPLE && enable && trig_hit;
  assign conv_end      = state_ff == ST_CONVERT && enable && tick &&
                         tad_cnt_ff == 4'(CONV_TADS - 1);
  assign last_smp      = smp_cnt_ff == smpi;
  assign hw_clr_sample = start_conv && trig_sel != TRIG_SOFT;
  assign hw_set_sample = enable && ctrl_one_ff[C1_AUTO] &&
                         (conv_end || state_ff == ST_IDLE);
  assign hw_set_done   = conv_end && last_smp;
  assign nxt_ch        = (ctrl_two_ff[C2_ALT] && alt_b_ff) ?
                         chan_sel_ff[CH_B_LSB +: 4] :
                         ctrl_two_ff[C2_SCAN] ?
                         next_scan(scan_sel_ff, scan_pos_ff) :
                         chan_sel_ff[3:0];

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      state_ff    <= ST_IDLE;
      tad_cnt_ff  <= 4'h0;
      auto_sample_clocks_cnt_ff <= 5'h00;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          tad_cnt_ff  <= 4'h0;
          auto_sample_clocks_cnt_ff <= 5'h00;
          if (enable && ctrl_one_ff[C1_SAMPLE]) begin
            state_ff <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          if (!enable) begin
            state_ff <= ST_IDLE;
          end else if (start_conv) begin
            state_ff   <= ST_CONVERT;
            tad_cnt_ff <= 4'h0;
          end else if (tick && auto_sample_clocks_cnt_ff != 5'h1f) begin
            auto_sample_clocks_cnt_ff <= auto_sample_clocks_cnt_ff + 5'h01;
          end
        end
        ST_CONVERT: begin
          if (!enable) begin
            state_ff   <= ST_ABORT;
            tad_cnt_ff <= 4'h0;
          end else if (conv_end) begin
            state_ff    <= ST_IDLE;
            auto_sample_clocks_cnt_ff <= 5'h00;
          end else if (tick) begin
            tad_cnt_ff <= tad_cnt_ff + 4'h1;
          end
        end
        ST_ABORT: begin
          if (tick && tad_cnt_ff == 4'(ABORT_TADS - 1)) begin
            state_ff <= ST_IDLE;
          end else if (tick) begin
            tad_cnt_ff <= tad_cnt_ff + 4'h1;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Sample count, buffer half, scan position and mux set
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      smp_cnt_ff  <= 4'h0;
      half_ff     <= 1'b0;
      scan_pos_ff <= 4'h0;
      alt_b_ff    <= 1'b0;
      cur_ch_ff   <= 4'h0;
    end else begin
      if (state_ff != ST_CONVERT) begin
        cur_ch_ff <= nxt_ch;
      end
      if (conv_end && last_smp) begin
        smp_cnt_ff  <= 4'h0;
        half_ff     <= ctrl_two_ff[C2_SPLIT] && !half_ff;
        scan_pos_ff <= 4'h0;
        alt_b_ff    <= 1'b0;
      end else if (conv_end) begin
        smp_cnt_ff  <= smp_cnt_ff + 4'h1;
        scan_pos_ff <= cur_ch_ff + 4'h1;
        alt_b_ff    <= !alt_b_ff;
      end
    end
  end

  // Result buffer, aborted conversions never land
  always_ff @(posedge i_sys_clk) begin
    if (conv_end) begin
      result_mem[{half_ff, 3'h0} + smp_cnt_ff] <= o_dac_code;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  assign wr_go  = aw_have_ff && w_have_ff && !o_bvalid;
  assign wr_val = merge(16'h0000, w_data_ff, w_strb_ff);
  assign wr_one = merge(ctrl_one_ff, w_data_ff, w_strb_ff);
  assign wr_two = merge(ctrl_two_ff, w_data_ff, w_strb_ff);

  function automatic logic hit(input logic [7:0] off);
    hit = wr_go && aw_addr_ff == off;
  endfunction

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_one_ff <= REG_RST;
    end else begin
      if (hit(OFF_CTRL_ONE)) begin
        ctrl_one_ff[C1_ENABLE]  <= wr_one[C1_ENABLE];
        ctrl_one_ff[C1_SAMPLE]  <= wr_one[C1_SAMPLE] || hw_set_sample;
        ctrl_one_ff[C1_DONE]    <= wr_one[C1_DONE] || hw_set_done;
        if (!enable) begin
          ctrl_one_ff[C1_TRIG_LSB +: 3] <= wr_one[C1_TRIG_LSB +: 3];
          ctrl_one_ff[C1_AUTO]          <= wr_one[C1_AUTO];
        end
      end else begin
        if (hw_set_sample) begin
          ctrl_one_ff[C1_SAMPLE] <= 1'b1;
        end else if (hw_clr_sample) begin
          ctrl_one_ff[C1_SAMPLE] <= 1'b0;
        end
        if (hw_set_done) begin
          ctrl_one_ff[C1_DONE] <= 1'b1;
        end else if (start_conv) begin
          ctrl_one_ff[C1_DONE] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_two_ff <= REG_RST;
    end else if (hit(OFF_CTRL_TWO)) begin
      ctrl_two_ff[C2_REF_EXT] <= wr_two[C2_REF_EXT];
      ctrl_two_ff[C2_SCAN]    <= wr_two[C2_SCAN];
      if (!enable) begin
        ctrl_two_ff[5:0] <= wr_two[5:0];
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_three_ff <= REG_RST;
      scan_sel_ff   <= REG_RST;
      chan_sel_ff   <= REG_RST;
      pin_cfg_ff    <= REG_RST;
      irq_mask_ff   <= REG_RST;
    end else begin
      if (hit(OFF_CTRL_THREE) && !enable) begin
        ctrl_three_ff <= wr_val & 16'h1fbf;
      end
      if (hit(OFF_SCAN_SEL) && !enable) begin
        scan_sel_ff <= wr_val & 16'h03ff;
      end
      if (hit(OFF_CHAN_SEL)) begin
        chan_sel_ff <= wr_val & 16'h0f0f;
      end
      if (hit(OFF_PIN_CFG)) begin
        pin_cfg_ff <= wr_val & 16'h03ff;
      end
      if (hit(OFF_IRQ_MASK)) begin
        irq_mask_ff <= wr_val & 16'h0001;
      end
    end
  end

  // Sticky converter flag, set beats write-one-to-clear
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      irq_stat_ff <= 1'b0;
      o_irq       <= 1'b0;
    end else begin
      irq_stat_ff <= hw_set_done ||
                     (irq_stat_ff && !(hit(OFF_IRQ_STATUS) && wr_val[0]));
      o_irq       <= irq_stat_ff && irq_mask_ff[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channels
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      aw_have_ff <= 1'b0;
      w_have_ff  <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff  <= 32'h0000_0000;
      w_strb_ff  <= 4'h0;
      o_awready  <= 1'b0;
      o_wready   <= 1'b0;
      o_bvalid   <= 1'b0;
      o_bresp    <= RESP_OKAY;
    end else begin
      if (o_awready && i_awvalid) begin
        aw_have_ff <= 1'b1;
        aw_addr_ff <= i_awaddr;
        o_awready  <= 1'b0;
      end else begin
        o_awready <= !aw_have_ff && !o_bvalid;
      end
      if (o_wready && i_wvalid) begin
        w_have_ff <= 1'b1;
        w_data_ff <= i_wdata;
        w_strb_ff <= i_wstrb;
        o_wready  <= 1'b0;
      end else begin
        o_wready <= !w_have_ff && !o_bvalid;
      end
      if (wr_go) begin
        aw_have_ff <= 1'b0;
        w_have_ff  <= 1'b0;
        o_bvalid   <= 1'b1;
        o_bresp    <= (mapped(aw_addr_ff) && aw_addr_ff < OFF_RESULT) ?
                      RESP_OKAY : RESP_SLV;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= RESP_OKAY;
    end else if (o_arready && i_arvalid) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b1;
      o_rresp   <= mapped(i_araddr) ? RESP_OKAY : RESP_SLV;
      case (i_araddr)
        OFF_CTRL_ONE:   o_rdata <= {16'h0000, ctrl_one_ff};
        OFF_CTRL_TWO:   o_rdata <= {16'h0000, ctrl_two_ff};
        OFF_CTRL_THREE: o_rdata <= {16'h0000, ctrl_three_ff};
        OFF_CHAN_SEL:   o_rdata <= {16'h0000, chan_sel_ff};
        OFF_PIN_CFG:    o_rdata <= {16'h0000, pin_cfg_ff};
        OFF_SCAN_SEL:   o_rdata <= {16'h0000, scan_sel_ff};
        OFF_IRQ_STATUS: o_rdata <= {31'h0000_0000, irq_stat_ff};
        OFF_IRQ_MASK:   o_rdata <= {16'h0000, irq_mask_ff};
        default: begin
          if (mapped(i_araddr) && i_araddr >= OFF_RESULT) begin
            o_rdata <= {20'h00000, result_mem[i_araddr[5:2]]};
          end else begin
            o_rdata <= 32'h0000_0000;
          end
        end
      endcase
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
    end else begin
      o_arready <= !o_rvalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Front end outputs
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_mux_sel    <= 4'h0;
      o_hold       <= 1'b0;
      o_ref_ext    <= 1'b0;
      o_pin_analog <= '0;
    end else begin
      o_mux_sel    <= cur_ch_ff;
      o_hold       <= state_ff == ST_CONVERT || start_conv;
      o_ref_ext    <= ctrl_two_ff[C2_REF_EXT];
      o_pin_analog <= ~pin_cfg_ff[N_INPUTS-1:0];
    end
  end
endmodule
`default_nettype wire

// >>> tb/sar_adc_sva.sv
// Port checker for the converter control core
`timescale 1ns/100ps
`default_nettype none
module sar_adc_sva (
  // Watched ports
  input wire logic        i_sys_clk, i_reset, i_bready, i_rready,
  input wire logic        o_awready, o_bvalid, o_arready, o_rvalid, o_hold,
  input wire logic [3:0]  o_mux_sel,
  input wire logic [31:0] o_rdata
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  a_wr_stands: assert property (o_bvalid && !i_bready |=> o_bvalid)
    else $error("bvalid dropped");
  a_rd_stands: assert property (o_rvalid && !i_rready |=>
    o_rvalid && $stable(o_rdata)) else $error("rvalid dropped");
  a_rd_upper: assert property (o_rvalid |-> o_rdata[31:16] == 16'h0)
    else $error("rdata upper set");
  a_rd_single: assert property (o_rvalid |-> !o_arready)
    else $error("arready in rvalid");
  a_wr_single: assert property (o_bvalid |-> !o_awready)
    else $error("awready in bvalid");
  a_wr_gap: assert property ($fell(o_bvalid) |-> !o_awready)
    else $error("awready too soon");
  a_hold_min: assert property ($rose(o_hold) |-> o_hold [*8])
    else $error("conversion too short");
  a_mux_steady: assert property (o_hold && $past(o_hold) |->
    $stable(o_mux_sel)) else $error("mux moved in hold");
endmodule
bind sar_adc_core sar_adc_sva i_sar_adc_sva (.*);
`default_nettype wire

// >>> tb/sar_adc_front_model.sv
// Front end model: tracking input, held while converting
`timescale 1ns/100ps
`default_nettype none
module sar_adc_front_model (
  // Core outputs seen by the front end
  input  wire logic        i_sys_clk, o_hold,
  input  wire logic [3:0]  o_mux_sel,
  input  wire logic [11:0] o_dac_code,
  // Comparator decision
  output logic             i_comp
);
  logic [11:0] held_ff;
  always_ff @(posedge i_sys_clk) begin
    if (!o_hold) held_ff <= {o_mux_sel, 8'ha5};
  end
  assign i_comp = held_ff >= o_dac_code;
endmodule
`default_nettype wire

// >>> tb/test_sar_adc_core.sv
// Bench for the converter control core
`timescale 1ns/100ps
`default_nettype none
module test_sar_adc_core
  import sar_adc_pkg::*;
;
  logic        i_sys_clk = 1'b0, i_rc_tick = 1'b0, i_sleep = 1'b0;
  logic        i_ext_trig = 1'b0, i_reset, i_bready, i_rready, i_comp;
  logic        i_awvalid, i_wvalid, i_arvalid, o_awready, o_wready;
  logic        o_bvalid, o_arready, o_rvalid, o_hold, o_ref_ext, o_irq;
  logic [1:0]  o_bresp, o_rresp;
  logic [3:0]  i_wstrb = 4'hf, o_mux_sel;
  logic [7:0]  i_awaddr, i_araddr;
  logic [9:0]  o_pin_analog;
  logic [11:0] o_dac_code;
  logic [31:0] i_wdata, o_rdata;
  int          num_errors, tests_run;
  sar_adc_core i_sar_adc_core (.*);
  sar_adc_front_model i_sar_adc_front_model (.*);
  initial forever #10 i_sys_clk = ~i_sys_clk;
  logic [3:0]  rc_div = 4'h0;
  always @(posedge i_sys_clk) begin
    rc_div    <= rc_div + 4'h1;
    i_rc_tick <= rc_div[3];
  end
  initial begin
    #100000;
    num_errors++;
    give_verdict;
  end
  task automatic chk(string n, logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] e = RESP_OKAY);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge i_sys_clk);
    {i_awvalid, i_wvalid} <= 2'h3;
    i_awaddr <= a;
    i_wdata <= d;
    do begin
      @(posedge i_sys_clk);
      if (o_awready === 1'b1 && !aw_done) begin
        i_awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (o_wready === 1'b1 && !w_done) begin
        i_wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end while (!(aw_done && w_done));
    repeat (2) @(posedge i_sys_clk);
    i_bready <= 1'b1;
    do @(posedge i_sys_clk); while (o_bvalid !== 1'b1);
    i_bready <= 1'b0;
    chk("bresp", o_bresp, e);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e, logic [1:0] r = RESP_OKAY);
    @(posedge i_sys_clk);
    i_arvalid <= 1'b1;
    i_araddr <= a;
    do @(posedge i_sys_clk); while (o_arready !== 1'b1);
    i_arvalid <= 1'b0;
    @(posedge i_sys_clk);
    i_rready <= 1'b1;
    do @(posedge i_sys_clk); while (o_rvalid !== 1'b1);
    i_rready <= 1'b0;
    chk("rdata", o_rdata, e);
    chk("rresp", o_rresp, r);
  endtask
  task automatic t_regs;
    rd(OFF_CTRL_ONE, 32'h0);
    rd(8'h24, 32'h0, RESP_SLV);
    wr(OFF_PIN_CFG, 32'h5);
    chk("pins", o_pin_analog, 32'h3fa);
    wr(OFF_CTRL_TWO, 32'h2000);
    chk("ref", o_ref_ext, 32'h1);
  endtask
  task automatic t_conv;
    int i;
    wr(OFF_CTRL_THREE, 32'h105);
    wr(OFF_CHAN_SEL, 32'h3);
    wr(OFF_IRQ_MASK, 32'h1);
    wr(OFF_CTRL_ONE, 32'h80e2);
    for (i = 0; i < 99 && o_hold !== 1'b1; i++) @(posedge i_sys_clk);
    chk("mux", o_mux_sel, 32'h3);
    for (i = 0; i < 99 && o_hold === 1'b1; i++) @(posedge i_sys_clk);
    chk("span", i > 77 && i < 91, 32'h1);
    for (i = 0; i < 20 && o_irq !== 1'b1; i++) @(posedge i_sys_clk);
    chk("irq", o_irq, 32'h1);
    rd(OFF_RESULT, 32'h3a5);
    wr(OFF_RESULT, 32'h0, RESP_SLV);
    rd(OFF_RESULT, 32'h3a5);
    wr(OFF_CTRL_THREE, 32'h0);
    rd(OFF_CTRL_THREE, 32'h105);
    wr(OFF_IRQ_MASK, 32'h0);
    chk("masked", o_irq, 32'h0);
    wr(OFF_IRQ_STATUS, 32'h1);
    wr(OFF_IRQ_MASK, 32'h1);
    chk("cleared", o_irq, 32'h0);
  endtask
  task automatic t_sleep;
    int i;
    wr(OFF_CTRL_ONE, 32'h0);
    wr(OFF_CTRL_THREE, 32'h185);
    wr(OFF_CHAN_SEL, 32'h7);
    wr(OFF_CTRL_ONE, 32'h8002);
    i_sleep <= 1'b1;
    wr(OFF_CTRL_ONE, 32'h8000);
    for (i = 0; i < 999 && o_irq !== 1'b1; i++) @(posedge i_sys_clk);
    chk("sleep irq", o_irq, 32'h1);
    i_sleep <= 1'b0;
    rd(OFF_RESULT, 32'h7a5);
  endtask
  task automatic give_verdict;
    $display("Checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h0;
    {i_awaddr, i_araddr, i_wdata} = 48'h0;
    i_reset = 1'b1;
    repeat (6) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    @(posedge i_sys_clk);
    t_regs;
    t_conv;
    t_sleep;
    give_verdict;
  end
endmodule
`default_nettype wire
